// ### verilog/bus_seq_pkg.sv
/*
  Package for the memory bus access sequencer: request kinds, pin levels,
  burst and page-run constants shared by the sequencer and its address unit.
  Assumes a single 250 MHz clock standing for the memory bus clock.
*/
package bus_seq_pkg;

  // ***************************************************************
  // request kinds
  // ***************************************************************
  typedef enum logic [2:0] {
    REQ_UNCACHED_READ,
    REQ_UNBUFFERED_WRITE,
    REQ_BUFFERED_WRITE,
    REQ_LINEFETCH,
    REQ_XLATE_L1,
    REQ_XLATE_L2,
    REQ_SWAP
  } req_kind_type;

  // ***************************************************************
  // pin levels and sizes
  // ***************************************************************
  localparam logic       CYCLE_IDLE       = 1'b1;
  localparam logic       CYCLE_MEMORY     = 1'b0;
  localparam logic       DIR_WRITE        = 1'b1;
  localparam logic       DIR_READ         = 1'b0;
  localparam logic       WIDTH_WORD       = 1'b1;
  localparam logic       WIDTH_BYTE       = 1'b0;
  localparam int         ADDR_W           = 32;
  localparam int         LEN_W            = 5;
  localparam logic [LEN_W-1:0] LINE_WORDS = 5'h04;
  localparam logic [LEN_W-1:0] ONE_WORD   = 5'h01;
  localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
  localparam int         PAGE_RUN_LSB     = 2;
  localparam int         PAGE_RUN_BITS    = 8;
  localparam int         QUAD_LSB         = 4;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;

endpackage

// ### verilog/seq_addr_step.sv
/*
  Address step and sequential classifier for the bus sequencer.
  Assumes the caller holds the previous access direction, width and address.
*/
`timescale 1ns/1ps
`default_nettype none
module seq_addr_step (
  input  wire logic [bus_seq_pkg::ADDR_W-1:0] prev_addr_in,
  input  wire logic                           prev_valid_in,
  input  wire logic                           prev_write_in,
  input  wire logic                           prev_word_in,
  input  wire logic [bus_seq_pkg::ADDR_W-1:0] next_addr_in,
  input  wire logic                           next_write_in,
  input  wire logic                           next_word_in,
  output logic      [bus_seq_pkg::ADDR_W-1:0] step_addr_out,
  output logic                                sequential_out
);
  import bus_seq_pkg::*;

  // ***************************************************************
  // classification
  // ***************************************************************
  wire logic same_type;
  wire logic consecutive;
  wire logic page_start;

  assign step_addr_out = prev_addr_in + WORD_STEP;
  // sequential needs same direction/width and exactly one word higher
  assign same_type   = (prev_write_in == next_write_in) && (prev_word_in == next_word_in);
  assign consecutive = (next_addr_in == step_addr_out);
  // a run is broken on each 256-word boundary so the mmu can recheck
  assign page_start  = (next_addr_in[PAGE_RUN_LSB +: PAGE_RUN_BITS] == '0);
  assign sequential_out = prev_valid_in && same_type && consecutive && !page_start;
endmodule
`default_nettype wire

// ### verilog/mem_bus_sequencer.sv
/*
  Memory bus access sequencer: turns one internal request at a time into
  idle and memory cycles with pipelined cycle-type, direction, width,
  address and lock outputs.
  Assumes the requester holds request fields stable while req_valid_in is high
  and the wait input is already synchronous to clock_in.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_bus_sequencer (
  input  wire logic                             clock_in,
  input  wire logic                             rst_in,
  input  wire logic                             req_valid_in,
  input  wire bus_seq_pkg::req_kind_type        req_kind_in,
  input  wire logic [bus_seq_pkg::ADDR_W-1:0]   req_addr_in,
  input  wire logic                             req_word_in,
  input  wire logic [bus_seq_pkg::LEN_W-1:0]    req_len_in,
  input  wire logic                             req_page_mapped_in,
  input  wire logic [bus_seq_pkg::ADDR_W-1:0]   req_l2_addr_in,
  input  wire logic                             swap_follows_in,
  input  wire logic                             wait_stretch_low_in,
  output logic                                  req_ready_out,
  output logic                                  memory_cycle_request_low_out,
  output logic                                  write_select_out,
  output logic                                  word_width_select_out,
  output logic      [bus_seq_pkg::ADDR_W-1:0]   addr_out,
  output logic                                  lock_out,
  output logic                                  data_phase_out,
  output logic                                  done_out
);
  import bus_seq_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_RUN, ST_END, ST_SWAP_GAP
  } state_type;

  // ***************************************************************
  // state
  // ***************************************************************
  state_type         state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              write_q, write_d;
  logic              word_q, word_d;
  logic              mreq_n_q, mreq_n_d;
  logic              lock_q, lock_d;
  logic              data_q, data_d;
  logic              done_q, done_d;
  logic              valid_q, valid_d;
  logic [LEN_W-1:0]  left_q, left_d;
  logic              swap_wr_q, swap_wr_d;   // swap write phase still owed
  logic              l2_owed_q, l2_owed_d;   // level 2 fetch still owed
  logic [ADDR_W-1:0] l2_addr_q, l2_addr_d;

  // ***************************************************************
  // request decode
  // ***************************************************************
  wire logic              advance;
  wire logic              kind_write;
  wire logic              kind_word;
  wire logic [ADDR_W-1:0] start_addr;
  wire logic [LEN_W-1:0]  start_len;
  wire logic              is_swap;
  wire logic [ADDR_W-1:0] step_addr;
  wire logic              next_seq;

  // a held wait freezes every output for whole cycles
  assign advance = wait_stretch_low_in;
  assign is_swap = (req_kind_in == REQ_SWAP);
  // buffered and unbuffered writes take the same path: no trace of which
  assign kind_write = (req_kind_in == REQ_UNBUFFERED_WRITE) ||
                      (req_kind_in == REQ_BUFFERED_WRITE);
  // linefetch and translation fetches force word width; others follow request
  assign kind_word = (req_kind_in == REQ_LINEFETCH) || (req_kind_in == REQ_XLATE_L1) ||
                     (req_kind_in == REQ_XLATE_L2) || req_word_in;
  assign start_addr = (req_kind_in == REQ_LINEFETCH) ?
                      {req_addr_in[ADDR_W-1:QUAD_LSB], {QUAD_LSB{1'b0}}} :
                      req_addr_in;
  assign start_len = (req_kind_in == REQ_LINEFETCH) ? LINE_WORDS :
                     (req_kind_in == REQ_XLATE_L1 || req_kind_in == REQ_XLATE_L2 ||
                      is_swap || req_len_in == '0) ? ONE_WORD : req_len_in;

  seq_addr_step u_step (
    .prev_addr_in   (addr_q),
    .prev_valid_in  (valid_q),
    .prev_write_in  (write_q),
    .prev_word_in   (word_q),
    .next_addr_in   (addr_q + WORD_STEP),
    .next_write_in  (write_q),
    .next_word_in   (word_q),
    .step_addr_out  (step_addr),
    .sequential_out (next_seq)
  );

  assign req_ready_out                = (state_q == ST_IDLE) && !l2_owed_q;
  assign memory_cycle_request_low_out = mreq_n_q;
  assign write_select_out             = write_q;
  assign word_width_select_out        = word_q;
  assign addr_out                     = addr_q;
  assign lock_out                     = lock_q;
  assign data_phase_out               = data_q;
  assign done_out                     = done_q;

  // ***************************************************************
  // sequencing: outputs name the following cycle, one cycle ahead
  // ***************************************************************
  always_comb begin
    state_d   = state_q;
    addr_d    = addr_q;     // idle keeps address and direction
    write_d   = write_q;
    word_d    = word_q;
    mreq_n_d  = mreq_n_q;
    lock_d    = lock_q;
    data_d    = 1'b0;
    done_d    = 1'b0;
    valid_d   = valid_q;
    left_d    = left_q;
    swap_wr_d = swap_wr_q;
    l2_owed_d = l2_owed_q;
    l2_addr_d = l2_addr_q;
    unique case (state_q)
      ST_IDLE: begin
        mreq_n_d = CYCLE_IDLE;
        if (l2_owed_q) begin
          // level 2 walk follows its level 1 fetch as a fresh word read
          addr_d    = l2_addr_q;
          write_d   = DIR_READ;
          word_d    = WIDTH_WORD;
          left_d    = ONE_WORD;
          l2_owed_d = 1'b0;
          state_d   = ST_START;
        end else if (req_valid_in) begin
          // every request opens non-sequentially: an idle with address out
          addr_d    = start_addr;
          write_d   = is_swap ? DIR_READ : kind_write;
          word_d    = kind_word;
          left_d    = start_len;
          lock_d    = is_swap;
          swap_wr_d = is_swap;
          l2_owed_d = (req_kind_in == REQ_XLATE_L1) && req_page_mapped_in;
          l2_addr_d = req_l2_addr_in;
          state_d   = ST_START;
        end
      end
      ST_START: begin
        mreq_n_d = CYCLE_MEMORY;
        valid_d  = 1'b1;
        state_d  = ST_RUN;
      end
      ST_RUN: begin
        data_d = 1'b1;
        left_d = left_q - ONE_WORD;
        if (left_q > ONE_WORD) begin
          addr_d = step_addr;
          if (next_seq) begin
            mreq_n_d = CYCLE_MEMORY;
          end else begin
            // boundary word reopens with an idle cycle, then resumes
            mreq_n_d = CYCLE_IDLE;
            state_d  = ST_START;
          end
        end else begin
          mreq_n_d = CYCLE_IDLE;
          state_d  = swap_wr_q ? ST_SWAP_GAP : ST_END;
        end
      end
      ST_SWAP_GAP: begin
        // read data cycle, then the write half at the locked address
        write_d   = DIR_WRITE;
        left_d    = ONE_WORD;
        swap_wr_d = 1'b0;
        mreq_n_d  = CYCLE_IDLE;
        state_d   = ST_START;
      end
      ST_END: begin
        // lock ends with the write unless another swap is lined up
        lock_d  = lock_q && swap_follows_in;
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q   <= ST_IDLE;
      addr_q    <= ADDR_RESET;
      write_q   <= DIR_READ;
      word_q    <= WIDTH_WORD;
      mreq_n_q  <= CYCLE_IDLE;
      lock_q    <= 1'b0;
      data_q    <= 1'b0;
      done_q    <= 1'b0;
      valid_q   <= 1'b0;
      left_q    <= '0;
      swap_wr_q <= 1'b0;
      l2_owed_q <= 1'b0;
      l2_addr_q <= ADDR_RESET;
    end else if (advance) begin
      state_q   <= state_d;
      addr_q    <= addr_d;
      write_q   <= write_d;
      word_q    <= word_d;
      mreq_n_q  <= mreq_n_d;
      lock_q    <= lock_d;
      data_q    <= data_d;
      done_q    <= done_d;
      valid_q   <= valid_d;
      left_q    <= left_d;
      swap_wr_q <= swap_wr_d;
      l2_owed_q <= l2_owed_d;
      l2_addr_q <= l2_addr_d;
    end
  end
endmodule
`default_nettype wire

// ### verif/seq_checker.sv
/*
  Checker for the bus sequencer: cycle type, direction, width, address and
  lock relations seen at the top ports. Assumes a bind onto mem_bus_sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module seq_checker (
  input wire logic                           clock_in,
  input wire logic                           rst_in,
  input wire logic                           req_valid_in,
  input wire bus_seq_pkg::req_kind_type      req_kind_in,
  input wire logic [bus_seq_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic                           req_word_in,
  input wire logic                           swap_follows_in,
  input wire logic                           wait_stretch_low_in,
  input wire logic                           req_ready_out,
  input wire logic                           memory_cycle_request_low_out,
  input wire logic                           write_select_out,
  input wire logic                           word_width_select_out,
  input wire logic [bus_seq_pkg::ADDR_W-1:0] addr_out,
  input wire logic                           lock_out,
  input wire logic                           data_phase_out,
  input wire logic                           done_out
);
  import bus_seq_pkg::*;
  logic              take;
  logic [ADDR_W-1:0] base_q;
  // a request counts only on an edge where the stall input is high
  assign take = req_valid_in && req_ready_out && wait_stretch_low_in;
  // address given with the request under way, before line alignment
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) base_q <= ADDR_RESET;
    else if (take) base_q <= req_addr_in;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ***************************************************************
  // properties
  // ***************************************************************
  property p_take_start;
    take |=> memory_cycle_request_low_out == CYCLE_IDLE && !req_ready_out;
  endproperty
  a_take_start: assert property (p_take_start) else $error("no idle start");
  property p_rw_type;
    take && req_kind_in inside {REQ_UNCACHED_READ, REQ_UNBUFFERED_WRITE, REQ_BUFFERED_WRITE}
    |=> write_select_out == ($past(req_kind_in) != REQ_UNCACHED_READ)
    && word_width_select_out == $past(req_word_in) && addr_out == base_q;
  endproperty
  a_rw_type: assert property (p_rw_type) else $error("access type wrong");
  property p_line_type;
    take && req_kind_in == REQ_LINEFETCH |=> word_width_select_out == WIDTH_WORD
    && addr_out[3:0] == 4'h0 && write_select_out == DIR_READ;
  endproperty
  a_line_type: assert property (p_line_type) else $error("line start wrong");
  property p_line_end;
    take && req_kind_in == REQ_LINEFETCH ##1 wait_stretch_low_in [*5] |=>
    memory_cycle_request_low_out == CYCLE_IDLE && addr_out == {base_q[31:4], 4'hC};
  endproperty
  a_line_end: assert property (p_line_end) else $error("line end wrong");
  property p_xlate;
    take && req_kind_in inside {REQ_XLATE_L1, REQ_XLATE_L2}
    |=> write_select_out == DIR_READ && word_width_select_out == WIDTH_WORD;
  endproperty
  a_xlate: assert property (p_xlate) else $error("table fetch type wrong");
  property p_swap_start;
    take && req_kind_in == REQ_SWAP |=> lock_out && write_select_out == DIR_READ
    && addr_out == base_q;
  endproperty
  a_swap_start: assert property (p_swap_start) else $error("swap start wrong");
  // lock falls on the same edge that raises done, unless a swap is lined up
  property p_lock_drop;
    done_out && $past(wait_stretch_low_in) && !$past(swap_follows_in) |-> !lock_out;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock held too long");
  property p_end_hold;
    done_out |-> $stable(addr_out) && $stable(write_select_out);
  endproperty
  a_end_hold: assert property (p_end_hold) else $error("end moved bus");
  property p_data_phase;
    data_phase_out && $past(wait_stretch_low_in) |-> !$past(memory_cycle_request_low_out);
  endproperty
  a_data_phase: assert property (p_data_phase) else $error("stray data phase");
  c_swap: cover property (take && req_kind_in == REQ_SWAP);
  c_line: cover property (take && req_kind_in == REQ_LINEFETCH);
  c_stall: cover property (!wait_stretch_low_in && !memory_cycle_request_low_out);
endmodule
`default_nettype wire

// ### verif/mem_side_model.sv
/*
  Memory side model: drives the stall input of the sequencer.
  Assumes the memory clock is the sequencer clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_side_model (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic slow_in,
  input  wire logic memory_cycle_request_low_in,
  output logic      wait_stretch_low_out
);
  // slow mode stretches each memory cycle by one whole cycle; the stall
  // input moves only while the clock is low, never near the rising edge
  always_ff @(negedge clock_in or posedge rst_in) begin
    if (rst_in) wait_stretch_low_out <= 1'b1;
    else wait_stretch_low_out <= !slow_in || memory_cycle_request_low_in
                                 || !wait_stretch_low_out;
  end
endmodule
`default_nettype wire

// ### verif/mem_bus_sequencer_test.sv
/*
  Testbench for the memory bus sequencer: issues each request kind except REQ_XLATE_L2 and
  compares the logged memory cycles. Assumes the checker and partner files.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_bus_sequencer_test;
  import bus_seq_pkg::*;
  logic              clock_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              req_valid_in = 1'b0;
  req_kind_type      req_kind_in = REQ_UNCACHED_READ;
  logic [ADDR_W-1:0] req_addr_in = 32'h0000_0000;
  logic              req_word_in = 1'b1;
  logic [LEN_W-1:0]  req_len_in = 5'h01;
  logic              req_page_mapped_in = 1'b0;
  logic [ADDR_W-1:0] req_l2_addr_in = 32'h0000_0000;
  logic              swap_follows_in = 1'b0;
  logic              slow = 1'b0;
  logic              wait_stretch_low_in, req_ready_out, memory_cycle_request_low_out;
  logic              write_select_out, word_width_select_out, lock_out, data_phase_out, done_out;
  logic [ADDR_W-1:0] addr_out;
  logic              last_mreq = 1'b1;
  logic [35:0]       mq[$];
  logic [35:0]       ex[$];
  int                num_errors = 0;
  int                num_checks = 0;
  always #2 clock_in = ~clock_in;
  mem_bus_sequencer mem_bus_sequencer_i (.clock_in, .rst_in, .req_valid_in, .req_kind_in,
    .req_addr_in, .req_word_in, .req_len_in, .req_page_mapped_in, .req_l2_addr_in,
    .swap_follows_in, .wait_stretch_low_in, .req_ready_out, .memory_cycle_request_low_out,
    .write_select_out, .word_width_select_out, .addr_out, .lock_out, .data_phase_out, .done_out);
  mem_side_model mem_side_model_i (.clock_in, .rst_in, .slow_in(slow),
    .memory_cycle_request_low_in(memory_cycle_request_low_out),
    .wait_stretch_low_out(wait_stretch_low_in));
  // log completed memory cycles as {lock, nonseq, write, word, addr}; stalled edges skipped
  always @(posedge clock_in) begin
    if (!rst_in && wait_stretch_low_in) begin
      if (!memory_cycle_request_low_out) mq.push_back({lock_out, last_mreq,
        write_select_out, word_width_select_out, addr_out});
      last_mreq <= memory_cycle_request_low_out;
    end
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] g, input logic [35:0] x);
    num_checks++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // issue one request, wait for nd completions (bounded), compare the log with ex
  task automatic go(input req_kind_type k, input logic [31:0] a, input logic w,
                    input logic [4:0] n, input logic pm, input int nd);
    int d;
    int t;
    d = 0;
    t = 0;
    mq.delete();
    @(posedge clock_in);
    req_valid_in <= 1'b1;
    req_kind_in <= k;
    req_addr_in <= a;
    req_word_in <= w;
    req_len_in <= n;
    req_page_mapped_in <= pm;
    while (d < nd && t < 300) begin
      @(negedge clock_in);
      #1;
      t++;
      if (done_out && wait_stretch_low_in) d++;
      if (req_valid_in && req_ready_out && wait_stretch_low_in) begin
        @(posedge clock_in);
        req_valid_in <= 1'b0;
      end
    end
    chk(36'(d), 36'(nd));
    chk(36'(mq.size()), 36'(ex.size()));
    foreach (ex[i]) chk(mq[i], ex[i]);
  endtask
  task automatic t_read;
    ex = '{36'h4_0000_0100, 36'h0_0000_0104, 36'h0_0000_0108};
    go(REQ_UNCACHED_READ, 32'h0000_0100, 1'b0, 5'h03, 1'b0, 1);
  endtask
  // both write kinds under a stalling memory side must look the same
  task automatic t_write;
    slow = 1'b1;
    ex = '{36'h7_0000_0200, 36'h3_0000_0204};
    go(REQ_UNBUFFERED_WRITE, 32'h0000_0200, 1'b1, 5'h02, 1'b0, 1);
    go(REQ_BUFFERED_WRITE, 32'h0000_0200, 1'b1, 5'h02, 1'b0, 1);
    slow = 1'b0;
  endtask
  task automatic t_line;
    ex = '{36'h5_0000_1230, 36'h1_0000_1234, 36'h1_0000_1238, 36'h1_0000_123C};
    go(REQ_LINEFETCH, 32'h0000_1237, 1'b0, 5'h01, 1'b0, 1);
  endtask
  task automatic t_xlate;
    req_l2_addr_in <= 32'h0000_9004;
    ex = '{36'h5_0000_8000, 36'h5_0000_9004};
    go(REQ_XLATE_L1, 32'h0000_8000, 1'b0, 5'h02, 1'b1, 2);
  endtask
  task automatic t_swap;
    ex = '{36'hC_0000_0044, 36'hE_0000_0044};
    // first swap announces a second one, so lock must stay up between them
    swap_follows_in <= 1'b1;
    go(REQ_SWAP, 32'h0000_0044, 1'b0, 5'h01, 1'b0, 1);
    chk({35'h0, lock_out}, 36'h1);
    swap_follows_in <= 1'b0;
    go(REQ_SWAP, 32'h0000_0044, 1'b0, 5'h01, 1'b0, 1);
    @(negedge clock_in);
    #1;
    chk({35'h0, lock_out}, 36'h0);
  endtask
  // a run across a 256-word edge restarts as non-sequential
  task automatic t_edge;
    ex = '{36'h5_0000_03FC, 36'h5_0000_0400, 36'h1_0000_0404};
    go(REQ_UNCACHED_READ, 32'h0000_03FC, 1'b1, 5'h03, 1'b0, 1);
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    t_read;
    t_write;
    t_line;
    t_xlate;
    t_swap;
    t_edge;
    end_sim;
  end
  // all scenarios need well under a thousand cycles
  initial begin
    #20000;
    num_errors++;
    end_sim;
  end
endmodule
bind mem_bus_sequencer seq_checker seq_checker_i (.clock_in, .rst_in, .req_valid_in,
  .req_kind_in, .req_addr_in, .req_word_in, .swap_follows_in, .wait_stretch_low_in,
  .req_ready_out, .memory_cycle_request_low_out, .write_select_out, .word_width_select_out,
  .addr_out, .lock_out, .data_phase_out, .done_out);
`default_nettype wire
